/* File: verilog/downstream_mem_window_bars.sv */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
// Function
// [R01] prefetch bit 3 read-only, reflects setup
// [R02] base field size/type from setup register; window 2 type is fixed at 00, whatever setup2 holds
// [R03] setup bit 31 clear disables window
// [R04] window sizes 4 KB to 2 GB
// [R05] hits translated through translated-base value
// [R06] base bit writable only where setup one
// [R07] base resets zero; zero base claims nothing
// [R08] third window type field 00 or 01
// [R09] bits 11:4 read zero, ignore writes
module downstream_mem_window_bars
    import dmw_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // companion setup words, held by the csr block
    input wire logic [31:0] setup2,
    input wire logic [31:0] setup3,
    input wire logic [31:0] xlate2,
    // downstream address probe for the second window
    input wire logic txn_valid,
    input wire logic [31:0] txn_addr,
    output logic hit2,
    output logic fwd_valid,
    output logic [31:0] fwd_addr
);
    // base field of window 2 (index 0) and window 3 (index 1)
    logic [BASE_W-1:0] base_ff [2];
    logic [31:0] setup_w [2]; // setup word per window
    bus_st_t st_ff; // bus slave state
    logic [11:0] addr_ff; // latched address phase offset
    logic wr_ff; // write data phase pending
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic hit2_ff;
    logic fwd_valid_ff;
    logic [31:0] fwd_addr_ff;
    logic take_c; // address phase taken this edge
    logic [BASE_W-1:0] win2_m; // writable / decode mask, window 2
    logic win2_en; // window 2 may claim
    logic hit2_c;
    logic [31:0] fwd_c;
    logic [1:0] type3_c;

    // index the setup words so the write loop can share one body
    assign setup_w[0] = setup2;
    assign setup_w[1] = setup3;

    // compose a base word; bits the setup leaves clear read as zero
    function automatic logic [31:0] bar_word(
        input logic [BASE_W-1:0] base,
        input logic [31:0] setup,
        input logic [1:0] atype
    );
        return {base & setup[BASE_MSB:BASE_LSB], RSV_VAL, setup[PREF_BIT], atype, SPACE_MEM};
    endfunction

    // window 3 type: reserved codes fall back to 32-bit decode
    always_comb begin
        if (setup3[TYPE_MSB:TYPE_LSB] == TYPE_64) begin
            type3_c = TYPE_64; // R08
        end else begin
            type3_c = TYPE_32; // R08
        end
    end

    // address phase is taken only when the bus is ready and nonseq
    assign take_c = hsel && hready && (htrans == HTRANS_NONSEQ);

    // bus slave sequencing; reads cost one wait state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= ST_IDLE;
            addr_ff <= 12'h000;
            wr_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    wr_ff <= take_c && hwrite;
                    if (take_c) begin
                        addr_ff <= haddr[11:0];
                    end
                    // read data is formed a cycle late so a write just
                    // before it is already visible
                    if (take_c && !hwrite) begin
                        st_ff <= ST_RDWAIT;
                        hreadyout_ff <= 1'b0;
                    end
                end
                ST_RDWAIT: begin
                    wr_ff <= 1'b0;
                    st_ff <= ST_IDLE;
                    hreadyout_ff <= 1'b1;
                end
            endcase
        end
    end

    // read data register, loaded in the wait state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata_ff <= DATA_RST;
        end else if (st_ff == ST_RDWAIT) begin
            unique case (addr_ff)
                WIN2_BASE_OFS: hrdata_ff <= bar_word(base_ff[0], setup2, TYPE_32); // R01 R09
                WIN3_BASE_OFS: hrdata_ff <= bar_word(base_ff[1], setup3, type3_c); // R08
                default: hrdata_ff <= DATA_RST; // unmapped reads zero
            endcase
        end
    end

    // response is always okay
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hresp_ff <= HRESP_OKAY;
        end else begin
            hresp_ff <= HRESP_OKAY;
        end
    end

    // base fields; only bits the setup marks one take write data
    for (genvar w = 0; w < 2; w++) begin : g_win
        logic [11:0] ofs;
        assign ofs = (w == 0) ? WIN2_BASE_OFS : WIN3_BASE_OFS;
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                base_ff[w] <= BASE_RST; // R07
            end else if (wr_ff && (addr_ff == ofs)) begin
                // low bits 11:0 are fixed, so write data there is dropped
                base_ff[w] <= (base_ff[w] & ~setup_w[w][BASE_MSB:BASE_LSB])
                    | (hwdata[BASE_MSB:BASE_LSB] & setup_w[w][BASE_MSB:BASE_LSB]); // R02 R06 R09
            end
        end
    end

    // window 2 decode; mask bits 31:12 give sizes 4 KB up to 2 GB
    assign win2_m = setup2[BASE_MSB:BASE_LSB]; // R04
    assign win2_en = setup2[SETUP_EN_BIT] && (base_ff[0] != BASE_RST); // R03 R07
    assign hit2_c = win2_en
        && ((txn_addr[BASE_MSB:BASE_LSB] & win2_m) == (base_ff[0] & win2_m)); // R04
    // direct translation: upper bits swapped for the translated base
    assign fwd_c = {(xlate2[BASE_MSB:BASE_LSB] & win2_m)
        | (txn_addr[BASE_MSB:BASE_LSB] & ~win2_m), txn_addr[BASE_LSB-1:0]}; // R05

    // registered probe answer, one cycle after the request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hit2_ff <= 1'b0;
            fwd_valid_ff <= 1'b0;
            fwd_addr_ff <= DATA_RST;
        end else begin
            // a probe that misses still gets an answer, with hit low
            fwd_valid_ff <= txn_valid;
            hit2_ff <= txn_valid && hit2_c; // R03 R07
            if (txn_valid) begin
                fwd_addr_ff <= fwd_c; // R05
            end
        end
    end

    // every output is a flop, so nothing combinational leaves the block
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hit2 = hit2_ff;
    assign fwd_valid = fwd_valid_ff;
    assign fwd_addr = fwd_addr_ff;

    // ---- checks ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [31:0] setup2_q; // setup seen in the wait state
    logic [31:0] setup3_q;
    // setup as seen at each edge, compared one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            setup2_q <= DATA_RST;
            setup3_q <= DATA_RST;
        end else begin
            setup2_q <= setup2;
            setup3_q <= setup3;
        end
    end

    // named steps of a register access
    sequence rd_win2_s;
        st_ff == ST_RDWAIT && addr_ff == WIN2_BASE_OFS;
    endsequence
    sequence rd_win3_s;
        st_ff == ST_RDWAIT && addr_ff == WIN3_BASE_OFS;
    endsequence
    sequence wr_win2_s;
        wr_ff && addr_ff == WIN2_BASE_OFS;
    endsequence

    // readback fields of window 2 and 3, then window 2 write, decode, translation and read wait checks
    pref_bit_a: assert property (rd_win2_s |=> hrdata_ff[PREF_BIT] == setup2_q[PREF_BIT]) // R01
        else $error("prefetch bit does not follow setup");
    rsv_zero_a: assert property (rd_win2_s |=> hrdata_ff[RSV_MSB:RSV_LSB] == RSV_VAL) // R09
        else $error("reserved bits not zero");
    type_field_a: assert property (rd_win3_s |=> hrdata_ff[TYPE_MSB:TYPE_LSB] // R08
        == ((setup3_q[TYPE_MSB:TYPE_LSB] == TYPE_64) ? TYPE_64 : TYPE_32))
        else $error("address type field wrong");
    ro_bits_a: assert property (wr_win2_s |=> // R06
        ((base_ff[0] ^ $past(base_ff[0])) & ~setup2_q[BASE_MSB:BASE_LSB]) == BASE_RST)
        else $error("read-only base bit changed");
    wr_take_a: assert property (wr_win2_s |=> (base_ff[0] & setup2_q[BASE_MSB:BASE_LSB]) // R02
        == ($past(hwdata[BASE_MSB:BASE_LSB]) & setup2_q[BASE_MSB:BASE_LSB]))
        else $error("writable base bit lost write data");
    dis_claim_a: assert property (txn_valid && !setup2[SETUP_EN_BIT] |=> !hit2_ff) // R03
        else $error("disabled window claimed access");
    zero_claim_a: assert property (txn_valid && base_ff[0] == BASE_RST |=> !hit2_ff) // R07
        else $error("zero base claimed access");
    range_hit_a: assert property (txn_valid && win2_en && !hit2_c |=> fwd_valid_ff && !hit2_ff) // R04
        else $error("access outside window claimed");
    xlate_a: assert property (txn_valid |=> fwd_addr_ff == // R05
        {($past(xlate2[BASE_MSB:BASE_LSB]) & $past(setup2[BASE_MSB:BASE_LSB]))
        | ($past(txn_addr[BASE_MSB:BASE_LSB]) & ~$past(setup2[BASE_MSB:BASE_LSB])),
        $past(txn_addr[BASE_LSB-1:0])})
        else $error("forwarded address wrong");
    rd_ready_a: assert property (take_c && !hwrite && st_ff == ST_IDLE |=> !hreadyout_ff ##1 hreadyout_ff)
        else $error("read wait state wrong");

    // window 3 write path mirrors window 2
    sequence wr_win3_s;
        wr_ff && addr_ff == WIN3_BASE_OFS;
    endsequence
    // read of an offset that maps to neither window
    sequence rd_none_s;
        st_ff == ST_RDWAIT && addr_ff != WIN2_BASE_OFS && addr_ff != WIN3_BASE_OFS;
    endsequence
    // probe that lands inside an enabled, nonzero window 2
    sequence probe_in2_s;
        txn_valid && setup2[SETUP_EN_BIT] && base_ff[0] != BASE_RST
            && ((txn_addr[BASE_MSB:BASE_LSB] ^ base_ff[0])
            & setup2[BASE_MSB:BASE_LSB]) == BASE_RST;
    endsequence

    // the space bit and window 2 type are fixed
    space_bit_a: assert property (rd_win2_s |=> hrdata_ff[SPACE_BIT] == SPACE_MEM)
        else $error("window 2 space bit not memory");
    space3_bit_a: assert property (rd_win3_s |=> hrdata_ff[SPACE_BIT] == SPACE_MEM)
        else $error("window 3 space bit not memory");
    w2_type_a: assert property (rd_win2_s |=> hrdata_ff[TYPE_MSB:TYPE_LSB] == TYPE_32)
        else $error("window 2 type field not 32-bit");

    // base bits read back only where the setup mask is one; reserved and unmapped reads give zero
    base_read_a: assert property (rd_win2_s |=> hrdata_ff[BASE_MSB:BASE_LSB] // R06
        == ($past(base_ff[0]) & setup2_q[BASE_MSB:BASE_LSB]))
        else $error("window 2 base readback wrong");
    base3_read_a: assert property (rd_win3_s |=> hrdata_ff[BASE_MSB:BASE_LSB] // R06
        == ($past(base_ff[1]) & setup3_q[BASE_MSB:BASE_LSB]))
        else $error("window 3 base readback wrong");
    rsv3_zero_a: assert property (rd_win3_s |=> hrdata_ff[RSV_MSB:RSV_LSB] == RSV_VAL)
        else $error("window 3 reserved bits not zero");
    unmapped_read_a: assert property (rd_none_s |=> hrdata_ff == DATA_RST)
        else $error("unmapped read not zero");

    // window 3 writes obey the setup3 mask, as window 2 writes obey setup2
    ro3_bits_a: assert property (wr_win3_s |=> // R06
        ((base_ff[1] ^ $past(base_ff[1])) & ~setup3_q[BASE_MSB:BASE_LSB]) == BASE_RST)
        else $error("read-only window 3 base bit changed");
    wr3_take_a: assert property (wr_win3_s |=> (base_ff[1] & setup3_q[BASE_MSB:BASE_LSB]) // R02
        == ($past(hwdata[BASE_MSB:BASE_LSB]) & setup3_q[BASE_MSB:BASE_LSB]))
        else $error("writable window 3 base bit lost write data");

    // no write strobe, no change of either base field
    base_hold_a: assert property (!wr_ff |=> $stable(base_ff[0]) && $stable(base_ff[1])) // R06
        else $error("base field changed without write");

    // probe answer shape: one answer per probe, hit only with it
    fwd_pulse_a: assert property (txn_valid |=> fwd_valid_ff)
        else $error("probe not answered");
    fwd_idle_a: assert property (!txn_valid |=> !fwd_valid_ff && !hit2_ff)
        else $error("answer without probe");
    fwd_hold_a: assert property (!txn_valid |=> $stable(fwd_addr_ff)) // R05
        else $error("forwarded address moved without probe");
    in_window_a: assert property (probe_in2_s |=> hit2_ff) // R04
        else $error("access inside window not claimed");

    // bus side: okay only, one wait state per read, none per write
    resp_okay_a: assert property (hresp_ff == HRESP_OKAY)
        else $error("response not okay");
    wr_ready_a: assert property (take_c && hwrite && st_ff == ST_IDLE |=> hreadyout_ff)
        else $error("write stalled");
    wait_once_a: assert property (!hreadyout_ff |=> hreadyout_ff)
        else $error("wait state longer than one cycle");
    st_onehot_a: assert property ($onehot(st_ff))
        else $error("bus state not one-hot");
    rd_hold_a: assert property (st_ff != ST_RDWAIT |=> $stable(hrdata_ff))
        else $error("read data moved outside a read");
endmodule // downstream_mem_window_bars

/* File: common/dmw_pkg.sv */
package dmw_pkg;
    // byte addresses of the two window base registers
    localparam logic [11:0] WIN2_BASE_OFS = 12'h01c;
    localparam logic [11:0] WIN3_BASE_OFS = 12'h020;
    // field positions inside a window base word
    localparam int SPACE_BIT = 0;
    localparam int TYPE_LSB = 1;
    localparam int TYPE_MSB = 2;
    localparam int PREF_BIT = 3;
    localparam int RSV_LSB = 4;
    localparam int RSV_MSB = 11;
    localparam int BASE_LSB = 12;
    localparam int BASE_MSB = 31;
    localparam int BASE_W = 20;
    // enable bit of a companion setup word
    localparam int SETUP_EN_BIT = 31;
    // reset and fixed field values
    localparam logic [19:0] BASE_RST = 20'h00000;
    localparam logic [7:0] RSV_VAL = 8'h00;
    localparam logic SPACE_MEM = 1'b0;
    localparam logic [1:0] TYPE_32 = 2'b00;
    localparam logic [1:0] TYPE_64 = 2'b01;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    // ahb-lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RDWAIT = 2'b10
    } bus_st_t;
endpackage

/* File: test/test_downstream_mem_window_bars.sv */
`timescale 1ns/1ns
module test_downstream_mem_window_bars;
    import dmw_pkg::*;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, txn_valid, hit2, fwd_valid; // nets
    logic [31:0] haddr, hwdata, hrdata, setup2, setup3, xlate2, txn_addr, fwd_addr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] rd; // last read word
    int err_count, samples_checked, cycles;
    assign hready = hreadyout; // one slave, so its ready is the bus ready
    downstream_mem_window_bars dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .setup2(setup2), .setup3(setup3),
        .xlate2(xlate2), .txn_valid(txn_valid), .txn_addr(txn_addr), .hit2(hit2),
        .fwd_valid(fwd_valid), .fwd_addr(fwd_addr));
    // free-running clock, 20 ns period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // waits for an accepted phase; ready and data sampled mid-cycle, where they are settled
    task automatic wait_ack(output logic [31:0] d);
        logic r;
        do begin
            @(negedge clock);
            r = hready;
            d = hrdata;
            check(hresp, HRESP_OKAY, "hresp");
            @(posedge clock);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ack(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ack(rd);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp, what);
    endtask
    // one-cycle probe; answer looked at in the following cycle
    task automatic probe(input logic [31:0] a, input logic h, input logic [31:0] f);
        txn_valid <= 1'b1;
        txn_addr <= a;
        @(posedge clock);
        txn_valid <= 1'b0;
        @(negedge clock);
        check({31'h0, hit2}, {31'h0, h}, "hit2");
        check({31'h0, fwd_valid}, 32'h0000_0001, "fwd_valid");
        if (h) check(fwd_addr, f, "fwd_addr");
        @(posedge clock);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst, hsel, hwrite, txn_valid} = 4'b1000;
        {haddr, hwdata, txn_addr, xlate2, setup3} = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        setup2 = 32'hfff0_0008;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd_chk(WIN2_BASE_OFS, 32'h0000_0008, "w2 reset");
        rd_chk(WIN3_BASE_OFS, 32'h0000_0000, "w3 reset");
        $display("test reset done");
        bus(1'b1, WIN2_BASE_OFS, 32'h8010_0fff);
        rd_chk(WIN2_BASE_OFS, 32'h8010_0008, "w2 masked write");
        setup2 <= 32'hff00_0000;
        bus(1'b1, WIN2_BASE_OFS, 32'h0000_0000);
        rd_chk(WIN2_BASE_OFS, 32'h0000_0000, "w2 narrow mask");
        setup2 <= 32'hfff0_0000;
        rd_chk(WIN2_BASE_OFS, 32'h0010_0000, "w2 held bits");
        $display("test write mask done");
        bus(1'b1, WIN2_BASE_OFS, 32'h8010_0000);
        xlate2 <= 32'h4000_0000;
        probe(32'h8012_3456, 1'b1, 32'h4002_3456);
        probe(32'h9010_0000, 1'b0, 32'h0000_0000);
        setup2 <= 32'h7ff0_0000;
        probe(32'h8012_3456, 1'b0, 32'h0000_0000);
        setup2 <= 32'hfff0_0000;
        bus(1'b1, WIN2_BASE_OFS, 32'h0000_0000);
        probe(32'h0000_0000, 1'b0, 32'h0000_0000);
        $display("test decode done");
        setup2 <= 32'hffff_f000;
        bus(1'b1, WIN2_BASE_OFS, 32'h1234_5fff);
        rd_chk(WIN2_BASE_OFS, 32'h1234_5000, "4k window");
        setup2 <= 32'h8000_0000;
        bus(1'b1, WIN2_BASE_OFS, 32'hffff_ffff);
        rd_chk(WIN2_BASE_OFS, 32'h8000_0000, "2g window");
        probe(32'hfedc_ba98, 1'b1, 32'h7edc_ba98);
        $display("test sizes done");
        setup3 <= 32'hffff_f00a;
        bus(1'b1, WIN3_BASE_OFS, 32'hffff_ffff);
        rd_chk(WIN3_BASE_OFS, 32'hffff_f00a, "w3 64-bit type");
        setup3 <= 32'hffff_f000;
        rd_chk(WIN3_BASE_OFS, 32'hffff_f000, "w3 32-bit type");
        setup3 <= 32'hffff_f004;
        rd_chk(WIN3_BASE_OFS, 32'hffff_f000, "w3 reserved type");
        rd_chk(12'h040, 32'h0000_0000, "unmapped read");
        $display("test third window done");
        rst <= 1'b1;
        @(negedge clock);
        check(fwd_addr, DATA_RST, "fwd_addr in reset");
        check({31'h0, hreadyout}, 32'h0000_0001, "hreadyout in reset");
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd_chk(WIN2_BASE_OFS, 32'h0000_0000, "w2 after reset");
        rd_chk(WIN3_BASE_OFS, 32'h0000_0000, "w3 after reset");
        $display("test second reset done");
        complete_run();
    end
endmodule // test_downstream_mem_window_bars
